// file: hw/tt3_defs.svh
// Register map, field positions and counts of the third reload timer
// Operation
// - Split bit picks one 16-bit or two 8-bit
// - 16-bit rollover reloads and sets high flag
// - Timer irq on 16-bit rollover while irq enable input set
// - Low-byte irq too when its enable set
// - Split bytes reload from own reload byte
// - Split run bit gates high byte only
// - 16-bit mode run bit halts or counts
// - High byte source: system clock, /12, ext/8
// - Low byte same; external select shared
// - External divided tick synchronised to system clock
// - Low flag sets on low rollover always
// - Split high rollover sets high flag
// - Split irq on high, low if enabled
// - Hardware never clears overflow flags
// - Control bit layout 7,6,5,3,2,0
// - Control bits 4,1 read zero
// - Count bytes join or stand alone
`ifndef TT3_DEFS_SVH
`define TT3_DEFS_SVH

`define TT3_ADDR_CONTROL 8'h91
`define TT3_ADDR_RELOAD_LOW 8'h92
`define TT3_ADDR_RELOAD_HIGH 8'h93
`define TT3_ADDR_COUNT_LOW 8'h94
`define TT3_ADDR_COUNT_HIGH 8'h95

`define TT3_BIT_HIGH_FLAG 7
`define TT3_BIT_LOW_FLAG 6
`define TT3_BIT_LOW_IRQ_EN 5
`define TT3_BIT_SPLIT 3
`define TT3_BIT_RUN 2
`define TT3_BIT_EXT_SEL 0
`define TT3_CONTROL_MASK 8'hED

`define TT3_RESET_BYTE 8'h00
`define TT3_BYTE_MAX 8'hFF
`define TT3_BYTE_ONE 8'h01

`define TT3_DIV12_LAST 4'hB
`define TT3_EXT_DIV_LAST 3'h7

`endif

// file: hw/tt3_pkg.sv
// Types shared by the third reload timer modules
package tt3_pkg;

  typedef logic [7:0] tt3_byte_t;

  typedef enum logic {
    TT3_MODE_WIDE,
    TT3_MODE_SPLIT
  } tt3_mode_t;

  typedef struct packed {
    logic high_flag;
    logic low_flag;
    logic low_irq_en;
    logic split;
    logic run;
    logic ext_sel;
  } tt3_ctrl_t;

endpackage : tt3_pkg

// file: hw/tt3_tick_if.sv
// Count tick bundle from the tick source to the timer core
`timescale 1ns/1ps
`default_nettype none
interface tt3_tick_if;
  logic div12_tick;
  logic ext_tick;
  modport src (output div12_tick, output ext_tick);
  modport dst (input div12_tick, input ext_tick);
endinterface : tt3_tick_if
`default_nettype wire

// file: hw/tt3_tick_gen.sv
// Prescaler and external oscillator synchroniser for the timer
`timescale 1ns/1ps
`default_nettype none
`include "tt3_defs.svh"
module tt3_tick_gen (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ext_osc,
  tt3_tick_if.src tick
);
  import tt3_pkg::*;

  logic [3:0] div12_r;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic [2:0] ext_div_r;
  logic div12_tick_r;
  logic ext_tick_r;
  logic ext_rise;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      div12_r <= 4'h0;
      div12_tick_r <= 1'b0;
    end else if (div12_r == `TT3_DIV12_LAST) begin
      div12_r <= 4'h0;
      div12_tick_r <= 1'b1;
    end else begin
      div12_r <= div12_r + 4'h1;
      div12_tick_r <= 1'b0;
    end
  end

  // Only sync2_r reads sync1_r; edges are taken past the second stage
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= i_ext_osc;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign ext_rise = sync2_r & ~sync3_r;

  // Oscillator faster than the system clock would lose edges here
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ext_div_r <= 3'h0;
      ext_tick_r <= 1'b0;
    end else if (ext_rise) begin
      ext_div_r <= ext_div_r + 3'h1;
      ext_tick_r <= (ext_div_r == `TT3_EXT_DIV_LAST);
    end else begin
      ext_tick_r <= 1'b0;
    end
  end

  assign tick.div12_tick = div12_tick_r;
  assign tick.ext_tick = ext_tick_r;
endmodule : tt3_tick_gen
`default_nettype wire

// file: hw/tt3_timer.sv
// Third auto-reload timer: registers, counters, flags and request
`timescale 1ns/1ps
`default_nettype none
`include "tt3_defs.svh"
module tt3_timer (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire tt3_pkg::tt3_byte_t i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic i_irq_enable,
  input wire logic i_high_byte_clock_select,
  input wire logic i_low_byte_clock_select,
  input wire logic i_ext_osc,
  output logic [7:0] o_sfr_rdata,
  output logic o_irq_req,
  output logic o_high_overflow,
  output logic o_low_overflow
);
  import tt3_pkg::*;

  // Picks one count tick for a byte from its clock-select bits
  function automatic logic pick_tick(
    input logic byte_sel,
    input logic ext_sel,
    input logic div12_tick,
    input logic ext_tick
  );
    logic t;
    if (byte_sel) begin
      t = 1'b1;
    end else if (ext_sel) begin
      t = ext_tick;
    end else begin
      t = div12_tick;
    end
    return t;
  endfunction : pick_tick

  // Next value of an 8-bit auto-reload byte on one tick
  function automatic tt3_byte_t step_byte(
    input tt3_byte_t cur,
    input tt3_byte_t reload
  );
    tt3_byte_t v;
    if (cur == `TT3_BYTE_MAX) begin
      v = reload;
    end else begin
      v = cur + `TT3_BYTE_ONE;
    end
    return v;
  endfunction : step_byte

  tt3_tick_if tick_bus ();

  tt3_tick_gen u_tick (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ext_osc(i_ext_osc),
    .tick(tick_bus.src)
  );

  tt3_ctrl_t ctrl_r;
  tt3_ctrl_t ctrl_nxt;
  tt3_byte_t reload_low_r;
  tt3_byte_t reload_high_r;
  tt3_byte_t count_low_r;
  tt3_byte_t count_low_nxt;
  tt3_byte_t count_high_r;
  tt3_byte_t count_high_nxt;
  logic [7:0] rdata_r;
  logic irq_r;
  logic high_ovf_r;
  logic low_ovf_r;

  tt3_mode_t mode;
  logic low_tick;
  logic high_tick;
  logic wide_adv;
  logic low_adv;
  logic high_adv;
  logic low_wrap;
  logic high_wrap;
  logic set_high_flag;
  logic set_low_flag;
  logic wr_ctrl;
  logic wr_rll;
  logic wr_rlh;
  logic wr_cl;
  logic wr_ch;
  logic sel_ctrl;
  logic sel_rll;
  logic sel_rlh;
  logic sel_cl;
  logic sel_ch;
  logic irq_cond;
  tt3_byte_t ctrl_read;

  // Decoded once so reads and writes cannot disagree on the map
  always_comb begin
    sel_ctrl = 1'b0;
    sel_rll = 1'b0;
    sel_rlh = 1'b0;
    sel_cl = 1'b0;
    sel_ch = 1'b0;
    if (i_sfr_addr == `TT3_ADDR_CONTROL) begin
      sel_ctrl = 1'b1;
    end else if (i_sfr_addr == `TT3_ADDR_RELOAD_LOW) begin
      sel_rll = 1'b1;
    end else if (i_sfr_addr == `TT3_ADDR_RELOAD_HIGH) begin
      sel_rlh = 1'b1;
    end else if (i_sfr_addr == `TT3_ADDR_COUNT_LOW) begin
      sel_cl = 1'b1;
    end else if (i_sfr_addr == `TT3_ADDR_COUNT_HIGH) begin
      sel_ch = 1'b1;
    end
    wr_ctrl = sel_ctrl & i_sfr_wr;
    wr_rll = sel_rll & i_sfr_wr;
    wr_rlh = sel_rlh & i_sfr_wr;
    wr_cl = sel_cl & i_sfr_wr;
    wr_ch = sel_ch & i_sfr_wr;
  end

  assign mode = ctrl_r.split ? TT3_MODE_SPLIT : TT3_MODE_WIDE;

  // Tick selection, one source per byte
  always_comb begin
    low_tick = pick_tick(i_low_byte_clock_select, ctrl_r.ext_sel,
                         tick_bus.div12_tick, tick_bus.ext_tick);
  end

  always_comb begin
    high_tick = pick_tick(i_high_byte_clock_select, ctrl_r.ext_sel,
                          tick_bus.div12_tick, tick_bus.ext_tick);
  end

  // Advance enables, at most one step per system clock cycle
  always_comb begin
    wide_adv = 1'b0;
    low_adv = 1'b0;
    high_adv = 1'b0;
    case (mode)
      TT3_MODE_WIDE: begin
        // Wide count follows the low byte source
        wide_adv = ctrl_r.run & low_tick;
      end
      TT3_MODE_SPLIT: begin
        low_adv = low_tick;
        high_adv = ctrl_r.run & high_tick;
      end
      default: begin
        wide_adv = 1'b0;
      end
    endcase
  end

  // Rollover detection
  always_comb begin
    low_wrap = 1'b0;
    high_wrap = 1'b0;
    case (mode)
      TT3_MODE_WIDE: begin
        low_wrap = wide_adv & (count_low_r == `TT3_BYTE_MAX);
        high_wrap = low_wrap & (count_high_r == `TT3_BYTE_MAX);
      end
      TT3_MODE_SPLIT: begin
        low_wrap = low_adv & (count_low_r == `TT3_BYTE_MAX);
        high_wrap = high_adv & (count_high_r == `TT3_BYTE_MAX);
      end
      default: begin
        low_wrap = 1'b0;
      end
    endcase
    set_low_flag = low_wrap;
    set_high_flag = high_wrap;
  end

  // Count next values; a software write beats counting that cycle
  always_comb begin
    count_low_nxt = count_low_r;
    count_high_nxt = count_high_r;
    case (mode)
      TT3_MODE_WIDE: begin
        if (high_wrap) begin
          count_low_nxt = reload_low_r;
          count_high_nxt = reload_high_r;
        end else if (wide_adv) begin
          count_low_nxt = count_low_r + `TT3_BYTE_ONE;
          if (low_wrap) begin
            count_high_nxt = count_high_r + `TT3_BYTE_ONE;
          end
        end
      end
      TT3_MODE_SPLIT: begin
        if (low_adv) begin
          count_low_nxt = step_byte(count_low_r, reload_low_r);
        end
        if (high_adv) begin
          count_high_nxt = step_byte(count_high_r, reload_high_r);
        end
      end
      default: begin
        count_low_nxt = count_low_r;
      end
    endcase
    if (wr_cl) begin
      count_low_nxt = i_sfr_wdata;
    end
    if (wr_ch) begin
      count_high_nxt = i_sfr_wdata;
    end
  end

  // Control next value; a hardware set wins over a clearing write
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt.high_flag = i_sfr_wdata[`TT3_BIT_HIGH_FLAG];
      ctrl_nxt.low_flag = i_sfr_wdata[`TT3_BIT_LOW_FLAG];
      ctrl_nxt.low_irq_en = i_sfr_wdata[`TT3_BIT_LOW_IRQ_EN];
      ctrl_nxt.split = i_sfr_wdata[`TT3_BIT_SPLIT];
      ctrl_nxt.run = i_sfr_wdata[`TT3_BIT_RUN];
      ctrl_nxt.ext_sel = i_sfr_wdata[`TT3_BIT_EXT_SEL];
    end
    // Flags only ever set here, never cleared by hardware
    if (set_high_flag) begin
      ctrl_nxt.high_flag = 1'b1;
    end
    if (set_low_flag) begin
      ctrl_nxt.low_flag = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Reload bytes only change on a software write
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      reload_low_r <= `TT3_RESET_BYTE;
    end else if (wr_rll) begin
      reload_low_r <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      reload_high_r <= `TT3_RESET_BYTE;
    end else if (wr_rlh) begin
      reload_high_r <= i_sfr_wdata;
    end
  end

  // Software writes are already folded into the next values
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      count_low_r <= `TT3_RESET_BYTE;
    end else begin
      count_low_r <= count_low_nxt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      count_high_r <= `TT3_RESET_BYTE;
    end else begin
      count_high_r <= count_high_nxt;
    end
  end

  // Control readback with the unused bits forced low
  always_comb begin
    ctrl_read = `TT3_RESET_BYTE;
    ctrl_read[`TT3_BIT_HIGH_FLAG] = ctrl_r.high_flag;
    ctrl_read[`TT3_BIT_LOW_FLAG] = ctrl_r.low_flag;
    ctrl_read[`TT3_BIT_LOW_IRQ_EN] = ctrl_r.low_irq_en;
    ctrl_read[`TT3_BIT_SPLIT] = ctrl_r.split;
    ctrl_read[`TT3_BIT_RUN] = ctrl_r.run;
    ctrl_read[`TT3_BIT_EXT_SEL] = ctrl_r.ext_sel;
    ctrl_read = ctrl_read & `TT3_CONTROL_MASK;
  end

  // Read data is registered, so it lags the strobe by one cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdata_r <= `TT3_RESET_BYTE;
    end else if (!i_sfr_rd) begin
      rdata_r <= `TT3_RESET_BYTE;
    end else if (sel_ctrl) begin
      rdata_r <= ctrl_read;
    end else if (sel_rll) begin
      rdata_r <= reload_low_r;
    end else if (sel_rlh) begin
      rdata_r <= reload_high_r;
    end else if (sel_cl) begin
      rdata_r <= count_low_r;
    end else if (sel_ch) begin
      rdata_r <= count_high_r;
    end else begin
      rdata_r <= `TT3_RESET_BYTE;
    end
  end

  // Request follows the sticky flags, so a late enable still sees them
  always_comb begin
    irq_cond = ctrl_r.high_flag | (ctrl_r.low_flag & ctrl_r.low_irq_en);
  end

  // Level request held while a qualifying flag stays set
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= i_irq_enable & irq_cond;
    end
  end

  // Overflow pulses for neighbours that count timer rollovers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      high_ovf_r <= 1'b0;
    end else begin
      high_ovf_r <= high_wrap;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      low_ovf_r <= 1'b0;
    end else begin
      low_ovf_r <= low_wrap;
    end
  end

  assign o_sfr_rdata = rdata_r;
  assign o_irq_req = irq_r;
  assign o_high_overflow = high_ovf_r;
  assign o_low_overflow = low_ovf_r;
endmodule : tt3_timer
`default_nettype wire

// file: testbench/tt3_timer_checker.sv
// Port assertions for the third reload timer
`timescale 1ns/1ps
`default_nettype none
`include "tt3_defs.svh"
module tt3_timer_checker (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire tt3_pkg::tt3_byte_t i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic i_irq_enable,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_irq_req,
  input wire logic o_high_overflow,
  input wire logic o_low_overflow
);
  import tt3_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Masked bits, since hardware may set flags between write and read
  property p_rw(a, m);
    tt3_byte_t d;
    (i_sfr_wr && i_sfr_addr == a, d = i_sfr_wdata) ##1
      !(i_sfr_wr && i_sfr_addr == a) ##1
      (i_sfr_rd && i_sfr_addr == a) |=> (o_sfr_rdata & m) == (d & m);
  endproperty
  chk_rdata_idle:
    assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00)
    else $error("read data without read");
  chk_unused_zero:
    assert property (i_sfr_rd && i_sfr_addr == 8'h91
      |=> o_sfr_rdata[4] == 1'b0 && o_sfr_rdata[1] == 1'b0)
    else $error("unused control bit set");
  chk_unmapped_zero:
    assert property (i_sfr_rd && (i_sfr_addr < 8'h91 || i_sfr_addr > 8'h95)
      |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_bits_rw:
    assert property (p_rw(8'h91, 8'h2D))
    else $error("control bits lost");
  chk_reload_low_rw:
    assert property (p_rw(8'h92, 8'hFF))
    else $error("low reload lost");
  chk_reload_high_rw:
    assert property (p_rw(8'h93, 8'hFF))
    else $error("high reload lost");
  chk_irq_needs_en:
    assert property (o_irq_req |-> $past(i_irq_enable))
    else $error("request while disabled");
  chk_irq_on_high:
    assert property (o_high_overflow && i_irq_enable && !i_sfr_wr
      |=> o_irq_req)
    else $error("no request after high overflow");
  chk_flag_sticky:
    assert property (o_irq_req && i_irq_enable && $past(i_irq_enable)
      && !i_sfr_wr && !$past(i_sfr_wr) |=> o_irq_req)
    else $error("request dropped without software");
  cover property (o_high_overflow);
  cover property (o_low_overflow && !o_high_overflow);
  cover property (o_irq_req);
endmodule : tt3_timer_checker
bind tt3_timer tt3_timer_checker u_tt3_timer_checker (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd),
  .i_irq_enable(i_irq_enable), .o_sfr_rdata(o_sfr_rdata),
  .o_irq_req(o_irq_req), .o_high_overflow(o_high_overflow),
  .o_low_overflow(o_low_overflow)
);
`default_nettype wire

// file: testbench/tt3_timer_test.sv
// Self-checking bench for the third reload timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  n_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tt3_timer_test;
  import tt3_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  tt3_byte_t wdata = 8'h00;
  logic rd = 1'b0;
  logic irq_en = 1'b0;
  logic hsel = 1'b0;
  logic lsel = 1'b0;
  logic osc = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic hov;
  logic lov;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  tt3_timer u_tt3_timer (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_wdata(wdata), .i_sfr_rd(rd), .i_irq_enable(irq_en),
    .i_high_byte_clock_select(hsel), .i_low_byte_clock_select(lsel),
    .i_ext_osc(osc), .o_sfr_rdata(rdata), .o_irq_req(irq),
    .o_high_overflow(hov), .o_low_overflow(lov)
  );

  always #50 i_mclk = ~i_mclk;

  // A hang anywhere ends the run through the same report
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      `CHK("timeout", 0, 1)
      wrap_up();
    end
  end

  task automatic put(input logic [7:0] a, input tt3_byte_t d);
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask : put

  task automatic get(input logic [7:0] a, input tt3_byte_t e);
    @(posedge i_mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : get

  task automatic wait_ev(input logic hi);
    repeat (60) begin
      @(posedge i_mclk);
      #1;
      if ((hi ? hov : lov) === 1'b1) return;
    end
    `CHK("overflow", 1'b1, 1'b0)
  endtask : wait_ev

  task wrap_up;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int a = 'h90; a < 'h97; a++) get(a[7:0], 8'h00);
    put(8'h91, 8'h12);
    get(8'h91, 8'h00);
    put(8'h92, 8'hA5);
    get(8'h92, 8'hA5);
    put(8'h93, 8'h5A);
    get(8'h93, 8'h5A);
    $display("test registers done");
    @(posedge i_mclk);
    lsel <= 1'b1;
    irq_en <= 1'b1;
    put(8'h92, 8'h34);
    put(8'h93, 8'h12);
    put(8'h94, 8'hFE);
    put(8'h95, 8'hFF);
    put(8'h91, 8'h04);
    wait_ev(1'b1);
    `CHK("low ovf", 1'b1, lov)
    get(8'h91, 8'hC4);
    `CHK("irq", 1'b1, irq)
    put(8'h91, 8'hC0);
    get(8'h95, 8'h12);
    repeat (20) @(posedge i_mclk);
    get(8'h91, 8'hC0);
    put(8'h94, 8'h10);
    repeat (5) @(posedge i_mclk);
    get(8'h94, 8'h10);
    put(8'h91, 8'h00);
    repeat (3) @(posedge i_mclk);
    #1;
    `CHK("irq", 1'b0, irq)
    put(8'h95, 8'h00);
    put(8'h94, 8'hF0);
    put(8'h91, 8'h24);
    wait_ev(1'b0);
    `CHK("high ovf", 1'b0, hov)
    @(posedge i_mclk);
    #1;
    `CHK("irq", 1'b1, irq)
    get(8'h91, 8'h64);
    put(8'h91, 8'h00);
    $display("test wide done");
    put(8'h95, 8'h77);
    put(8'h92, 8'h80);
    put(8'h94, 8'hFE);
    put(8'h91, 8'h08);
    wait_ev(1'b0);
    get(8'h95, 8'h77);
    `CHK("irq", 1'b0, irq)
    get(8'h91, 8'h48);
    put(8'h95, 8'hFF);
    put(8'h93, 8'h33);
    put(8'h91, 8'h0C);
    wait_ev(1'b1);
    get(8'h95, 8'h33);
    `CHK("irq", 1'b1, irq)
    $display("test split done");
    // Leave the divided source first so no stray tick lands on the write
    put(8'h91, 8'h0D);
    put(8'h95, 8'h00);
    repeat (32) begin
      repeat (2) @(posedge i_mclk);
      osc <= ~osc;
    end
    repeat (10) @(posedge i_mclk);
    get(8'h95, 8'h02);
    put(8'h91, 8'h00);
    $display("test external done");
    @(posedge i_mclk);
    hsel <= 1'b1;
    lsel <= 1'b0;
    put(8'h92, 8'h40);
    put(8'h94, 8'hFF);
    put(8'h91, 8'h08);
    wait_ev(1'b0);
    get(8'h94, 8'h40);
    put(8'h93, 8'h11);
    put(8'h95, 8'hFE);
    put(8'h91, 8'h0C);
    wait_ev(1'b1);
    get(8'h95, 8'h12);
    put(8'h91, 8'h00);
    $display("test sources done");
    wrap_up();
  end
endmodule : tt3_timer_test
`default_nettype wire
